// ### hdl/bus_pin_monitor.sv
// Synchroniser and start/stop/edge detector for the two bus pins
`timescale 1ns/1ps
module bus_pin_monitor (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         scl_in,
    input  wire logic                         sda_in,
    output slave_flag_pkg::bus_event_type     ev
);
    import slave_flag_pkg::*;

    logic [1:0] meta_reg;
    logic [1:0] sync_reg;
    logic [1:0] prev_reg;
    logic [1:0] pins;

    assign pins = {scl_in, sda_in};

    // ---------------------------------------------------------------
    // Two-stage synchronisers, bit 1 is SCL, bit 0 is SDA
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_reg[g] <= 1'b1;
                    sync_reg[g] <= 1'b1;
                    prev_reg[g] <= 1'b1;
                end else begin
                    meta_reg[g] <= pins[g];
                    sync_reg[g] <= meta_reg[g];
                    prev_reg[g] <= sync_reg[g];
                end
            end
        end
    endgenerate

    // Start and stop are SDA edges while SCL stays high on both samples
    always_comb begin
        ev.scl      = sync_reg[1];
        ev.sda      = sync_reg[0];
        ev.scl_rise = sync_reg[1] && !prev_reg[1];
        ev.scl_fall = !sync_reg[1] && prev_reg[1];
        ev.start    = sync_reg[1] && prev_reg[1] && prev_reg[0] && !sync_reg[0];
        ev.stop     = sync_reg[1] && prev_reg[1] && !prev_reg[0] && sync_reg[0];
    end
endmodule : bus_pin_monitor

// ### hdl/i2c_slave_flag_handling.sv
// Two-wire slave with address/stop and data flags, clock stretching and APB registers
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module i2c_slave_flag_handling #(
    parameter int TIMEOUT_CYCLES = slave_flag_pkg::TIMEOUT_CYCLES
) (
    input  wire logic                                pclk,
    input  wire logic                                presetn,
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [slave_flag_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [slave_flag_pkg::DATA_W-1:0]   pwdata,
    output logic      [slave_flag_pkg::DATA_W-1:0]   prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    output logic                                     irq,
    input  wire logic                                scl_in,
    output logic                                     scl_out,
    output logic                                     scl_oe_n,
    input  wire logic                                sda_in,
    output logic                                     sda_out,
    output logic                                     sda_oe_n
);
    import slave_flag_pkg::*;

    localparam logic [TMO_CNT_W-1:0] TMO_LAST = TMO_CNT_W'(TIMEOUT_CYCLES - 1);

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    bus_event_type        ev;
    link_state_type       state_reg, state_next;
    logic [2:0]           cnt_reg, cnt_next;
    logic [7:0]           sh_reg, sh_next;
    logic [7:0]           rx_data_reg, rx_data_next;
    logic [7:0]           tx_data_reg, tx_data_next;
    logic                 ack_rise_reg, ack_rise_next;
    logic                 rw_reg, rw_next;
    logic                 busy_reg, busy_next;
    logic [TMO_CNT_W-1:0] tmo_cnt_reg, tmo_cnt_next;
    logic [CTRL_W-1:0]    ctrl_reg, ctrl_next;
    logic [FLAG_W-1:0]    flags_reg, flags_next;
    logic [FLAG_W-1:0]    mask_reg, mask_next;
    logic                 ackact_reg, ackact_next;
    logic                 resp_clr_due_reg, resp_clr_due_next;
    logic                 hold_reg, hold_next;
    logic                 scl_oe_n_reg, scl_oe_n_next;
    logic                 sda_oe_n_reg, sda_oe_n_next;
    logic                 irq_reg, irq_next;
    logic [DATA_W-1:0]    prdata_reg, prdata_next;
    logic                 pready_reg, pready_next;
    logic                 pslverr_reg, pslverr_next;
    logic [1:0]           pin_out_reg;
    logic                 setup, wr_en, sts_wr, cmd_wr, cmd_resp_wr, cmd_done_wr;
    logic                 tmo_hit, stretch_ok, want_low;
    logic                 set_adrf, set_datf, set_txcol, set_tmo, clr_txcol;
    logic [FLAG_W-1:0]    set_vec, clr_vec;
    logic [6:0]           own_addr;
    logic [DATA_W-1:0]    rd_mux;

    bus_pin_monitor i_bus_pin_monitor (
        .pclk    (pclk),
        .presetn (presetn),
        .scl_in  (scl_in),
        .sda_in  (sda_in),
        .ev      (ev)
    );

    // ---------------------------------------------------------------
    // APB decode; zero-wait, read data captured in the setup cycle
    // ---------------------------------------------------------------
    assign setup       = psel && !penable;
    assign wr_en       = psel && penable && pready_reg && pwrite;
    assign sts_wr      = wr_en && hit(paddr, OFF_STATUS);
    assign cmd_wr      = wr_en && hit(paddr, OFF_CMD);
    assign cmd_resp_wr = cmd_wr && (pwdata[CMD_LSB+:2] == CMD_RESPONSE);
    assign cmd_done_wr = cmd_wr && (pwdata[CMD_LSB+:2] == CMD_COMPLETE);
    assign own_addr    = ctrl_reg[CTRL_ADDR_LSB+:7];
    assign tmo_hit     = ctrl_reg[CTRL_TMO_EN] && busy_reg && (tmo_cnt_reg == TMO_LAST);
    assign stretch_ok  = (state_reg != ST_IDLE) && (state_reg != ST_ADDR);

    always_comb begin
        rd_mux = '0;
        case (paddr)
            OFF_CTRL:   rd_mux = DATA_W'(ctrl_reg);
            OFF_STATUS: rd_mux = DATA_W'({rw_reg, ev.scl, busy_reg, hold_reg, flags_reg});
            OFF_MASK:   rd_mux = DATA_W'(mask_reg);
            OFF_CMD:    rd_mux = DATA_W'({ackact_reg, 2'h0});
            OFF_DATA:   rd_mux = DATA_W'(rx_data_reg);
            default:    rd_mux = '0;
        endcase
    end

    always_comb begin
        pready_next  = setup;
        pslverr_next = setup && !(hit(paddr, OFF_CTRL) || hit(paddr, OFF_STATUS) || hit(paddr, OFF_MASK)
                                  || hit(paddr, OFF_CMD) || hit(paddr, OFF_DATA));
        // A read taken right after a response command still sees the data flag set
        prdata_next  = (setup && !pwrite) ? rd_mux : prdata_reg;
        ctrl_next    = (wr_en && hit(paddr, OFF_CTRL)) ? (pwdata[CTRL_W-1:0] & CTRL_MASK) : ctrl_reg;
        mask_next    = (wr_en && hit(paddr, OFF_MASK)) ? pwdata[FLAG_W-1:0] : mask_reg;
        tx_data_next = (wr_en && hit(paddr, OFF_DATA)) ? pwdata[7:0] : tx_data_reg;
        ackact_next  = cmd_wr ? pwdata[CMD_ACKACT] : ackact_reg;
    end

    // ---------------------------------------------------------------
    // Link state machine, advanced by sampled SCL edges
    // ---------------------------------------------------------------
    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        sh_next       = sh_reg;
        rx_data_next  = rx_data_reg;
        ack_rise_next = ack_rise_reg;
        rw_next       = rw_reg;
        busy_next     = busy_reg;
        set_adrf      = 1'b0;
        set_datf      = 1'b0;
        set_txcol     = 1'b0;
        set_tmo       = 1'b0;
        clr_txcol     = 1'b0;
        // A start restarts the idle count, so a repeated start never waits out a wrapped counter
        if (ev.start || ev.scl_rise || ev.scl_fall || !busy_reg) begin
            tmo_cnt_next = '0;
        end else begin
            tmo_cnt_next = tmo_cnt_reg + 1'b1;
        end
        // Start is checked before the timeout so a coinciding start is not dropped
        if (ev.start) begin
            state_next = ST_ADDR;
            cnt_next   = 3'h0;
            busy_next  = 1'b1;
            clr_txcol  = 1'b1;
        end else if (ev.stop || tmo_hit) begin
            set_adrf   = ev.stop && stretch_ok;
            set_tmo    = !ev.stop;
            state_next = ST_IDLE;
            busy_next  = 1'b0;
        end else if (cmd_done_wr) begin
            state_next = ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    state_next = ST_IDLE;
                end
                ST_ADDR: begin
                    if (ev.scl_rise) begin
                        sh_next  = {sh_reg[6:0], ev.sda};
                        cnt_next = cnt_reg + 1'b1;
                        if (cnt_reg == 3'h7) begin
                            if (ctrl_reg[CTRL_EN] && sh_reg[6:0] == own_addr) begin
                                set_adrf      = 1'b1;
                                rw_next       = ev.sda;
                                ack_rise_next = 1'b0;
                                state_next    = ST_ADDR_ACK;
                            end else begin
                                state_next = ST_IDLE;
                            end
                        end
                    end
                end
                ST_ADDR_ACK, ST_RX_ACK: begin
                    if (ev.scl_rise) begin
                        ack_rise_next = 1'b1;
                    end else if (ev.scl_fall && ack_rise_reg) begin
                        cnt_next = 3'h0;
                        sh_next  = tx_data_reg;
                        if (ackact_reg) begin
                            state_next = ST_IDLE;
                        end else if (state_reg == ST_ADDR_ACK && rw_reg) begin
                            state_next = ST_TX;
                        end else begin
                            state_next = ST_RX;
                        end
                    end
                end
                ST_RX: begin
                    if (ev.scl_rise) begin
                        sh_next  = {sh_reg[6:0], ev.sda};
                        cnt_next = cnt_reg + 1'b1;
                        if (cnt_reg == 3'h7) begin
                            rx_data_next  = {sh_reg[6:0], ev.sda};
                            set_datf      = 1'b1;
                            ack_rise_next = 1'b0;
                            state_next    = ST_RX_ACK;
                        end
                    end
                end
                ST_TX: begin
                    // Reload while stretched so data written during the stall is sent
                    if (hold_reg) begin
                        sh_next = tx_data_reg;
                    end else if (ev.scl_rise && ev.sda != sh_reg[7]) begin
                        set_txcol = 1'b1;
                    end else if (ev.scl_fall) begin
                        sh_next  = {sh_reg[6:0], 1'b0};
                        cnt_next = cnt_reg + 1'b1;
                        if (cnt_reg == 3'h7) begin
                            ack_rise_next = 1'b0;
                            state_next    = ST_TX_ACK;
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (ev.scl_rise) begin
                        ack_rise_next = 1'b1;
                        set_datf      = !ev.sda;
                        state_next    = ev.sda ? ST_IDLE : ST_TX_ACK;
                    end else if (ev.scl_fall && ack_rise_reg) begin
                        cnt_next   = 3'h0;
                        sh_next    = tx_data_reg;
                        state_next = ST_TX;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Sticky flags, clock hold and pin drive
    // ---------------------------------------------------------------
    always_comb begin
        set_vec = '0;
        set_vec[ST_ADRF]  = set_adrf;
        set_vec[ST_DATF]  = set_datf;
        set_vec[ST_TXCOL] = set_txcol;
        set_vec[ST_TMO]   = set_tmo;
        clr_vec = sts_wr ? pwdata[FLAG_W-1:0] : '0;
        clr_vec[ST_TXCOL] = clr_vec[ST_TXCOL] | clr_txcol;
        clr_vec[ST_DATF]  = clr_vec[ST_DATF] | resp_clr_due_reg;
        // Set wins over clear, so a clear racing a new address never strands the hold
        flags_next        = (flags_reg & ~clr_vec) | set_vec;
        resp_clr_due_next = cmd_resp_wr;
        hold_next         = flags_next[ST_ADRF] | flags_next[ST_DATF];
        irq_next          = |(flags_next & mask_next);
        scl_oe_n_next     = !(hold_reg && !ev.scl && stretch_ok);
        // Decoded from the next state so SDA moves early in the low phase, not as SCL rises again
        case (state_next)
            ST_ADDR_ACK, ST_RX_ACK: want_low = !ackact_reg;
            ST_TX:                  want_low = !sh_next[7];
            default:                want_low = 1'b0;
        endcase
        // SDA is released whenever the next state is idle; otherwise it only changes while SCL is low and no stall is pending
        if (state_next == ST_IDLE) begin
            sda_oe_n_next = 1'b1;
        end else if (!ev.scl && !hold_reg) begin
            sda_oe_n_next = !want_low;
        end else begin
            sda_oe_n_next = sda_oe_n_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg        <= ST_IDLE;
            cnt_reg          <= 3'h0;
            sh_reg           <= 8'h00;
            rx_data_reg      <= 8'h00;
            tx_data_reg      <= 8'h00;
            ack_rise_reg     <= 1'b0;
            rw_reg           <= 1'b0;
            busy_reg         <= 1'b0;
            tmo_cnt_reg      <= '0;
            ctrl_reg         <= CTRL_RST;
            flags_reg        <= FLAGS_RST;
            mask_reg         <= MASK_RST;
            ackact_reg       <= 1'b0;
            resp_clr_due_reg <= 1'b0;
            hold_reg         <= 1'b0;
            scl_oe_n_reg     <= 1'b1;
            sda_oe_n_reg     <= 1'b1;
            irq_reg          <= 1'b0;
            prdata_reg       <= '0;
            pready_reg       <= 1'b0;
            pslverr_reg      <= 1'b0;
            pin_out_reg      <= 2'h0;
        end else begin
            state_reg        <= state_next;
            cnt_reg          <= cnt_next;
            sh_reg           <= sh_next;
            rx_data_reg      <= rx_data_next;
            tx_data_reg      <= tx_data_next;
            ack_rise_reg     <= ack_rise_next;
            rw_reg           <= rw_next;
            busy_reg         <= busy_next;
            tmo_cnt_reg      <= tmo_cnt_next;
            ctrl_reg         <= ctrl_next;
            flags_reg        <= flags_next;
            mask_reg         <= mask_next;
            ackact_reg       <= ackact_next;
            resp_clr_due_reg <= resp_clr_due_next;
            hold_reg         <= hold_next;
            scl_oe_n_reg     <= scl_oe_n_next;
            sda_oe_n_reg     <= sda_oe_n_next;
            irq_reg          <= irq_next;
            prdata_reg       <= prdata_next;
            pready_reg       <= pready_next;
            pslverr_reg      <= pslverr_next;
            pin_out_reg      <= 2'h0;
        end
    end

    assign prdata   = prdata_reg;
    assign pready   = pready_reg;
    assign pslverr  = pslverr_reg;
    assign irq      = irq_reg;
    assign scl_out  = pin_out_reg[1];
    assign sda_out  = pin_out_reg[0];
    assign scl_oe_n = scl_oe_n_reg;
    assign sda_oe_n = sda_oe_n_reg;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_txcol_start;
        ev.start |=> !flags_reg[ST_TXCOL];
    endproperty
    a_txcol_start: assert property (p_txcol_start) else $error("collision flag survived a start");

    property p_adrf_on_addr;
        (state_reg == ST_ADDR && ev.scl_rise && cnt_reg == 3'h7 && ctrl_reg[CTRL_EN] && sh_reg[6:0] == own_addr
         && !ev.start && !ev.stop && !tmo_hit && !cmd_done_wr)
        |=> flags_reg[ST_ADRF] && state_reg == ST_ADDR_ACK ##1 hold_reg;
    endproperty
    a_adrf_on_addr: assert property (p_adrf_on_addr) else $error("address match did not raise flag");

    property p_adrf_clear_release;
        (sts_wr && pwdata[ST_ADRF] && !set_adrf && !set_datf && !flags_reg[ST_DATF])
        |=> !hold_reg ##1 scl_oe_n_reg;
    endproperty
    a_adrf_clear_release: assert property (p_adrf_clear_release) else $error("SCL not released after clear");

    property p_stretch_low;
        (hold_reg && !ev.scl && stretch_ok) |=> !scl_oe_n_reg;
    endproperty
    a_stretch_low: assert property (p_stretch_low) else $error("SCL not held while flag pending");

    property p_tmo_start;
        (tmo_hit && ev.start) |=> state_reg == ST_ADDR && busy_reg && !flags_reg[ST_TMO] || $past(flags_reg[ST_TMO]);
    endproperty
    a_tmo_start: assert property (p_tmo_start) else $error("start lost to timeout");

    property p_datf_delay;
        (cmd_resp_wr && flags_reg[ST_DATF] && !set_datf) |=> flags_reg[ST_DATF] ##1 !flags_reg[ST_DATF];
    endproperty
    a_datf_delay: assert property (p_datf_delay) else $error("data flag clear not one cycle late");

    property p_datf_read;
        (cmd_resp_wr && flags_reg[ST_DATF] && !set_datf) ##1 (setup && !pwrite && paddr == OFF_STATUS)
        |=> prdata_reg[ST_DATF];
    endproperty
    a_datf_read: assert property (p_datf_read) else $error("status read missed pending data flag");

    property p_irq;
        ($rose(flags_reg[ST_DATF]) && mask_reg[ST_DATF]) |-> irq_reg;
    endproperty
    a_irq: assert property (p_irq) else $error("masked-in flag without interrupt");

    c_repeated_start: cover property (ev.start && state_reg != ST_IDLE);
    c_adrf_race:      cover property (sts_wr && pwdata[ST_ADRF] && set_adrf);
    c_tmo_start:      cover property (tmo_hit && ev.start);
    c_resp_cmd:       cover property (cmd_resp_wr && flags_reg[ST_DATF]);
endmodule : i2c_slave_flag_handling

// ### hdl/slave_flag_pkg.sv
// Shared constants and types for the two-wire slave flag block
package slave_flag_pkg;
    // ---------------------------------------------------------------
    // Bus and register map
    // ---------------------------------------------------------------
    localparam int              DATA_W     = 32;
    localparam int              ADDR_W     = 8;
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CMD    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_DATA   = 8'h10;

    // ---------------------------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------------------------
    localparam int              CTRL_EN       = 0;
    localparam int              CTRL_TMO_EN   = 1;
    localparam int              CTRL_ADDR_LSB = 8;
    localparam int              CTRL_W        = 15;
    localparam logic [CTRL_W-1:0] CTRL_MASK   = 15'h7F03;
    localparam logic [CTRL_W-1:0] CTRL_RST    = 15'h0000;
    localparam int              FLAG_W     = 4;
    localparam int              ST_ADRF    = 0;
    localparam int              ST_DATF    = 1;
    localparam int              ST_TXCOL   = 2;
    localparam int              ST_TMO     = 3;
    localparam int              ST_HOLD    = 4;
    localparam int              ST_BUSY    = 5;
    localparam int              ST_SCL     = 6;
    localparam int              ST_RW      = 7;
    localparam logic [FLAG_W-1:0] FLAGS_RST = 4'h0;
    localparam logic [FLAG_W-1:0] MASK_RST  = 4'h0;
    localparam int              CMD_LSB    = 0;
    localparam int              CMD_ACKACT = 2;
    localparam logic [1:0]      CMD_COMPLETE = 2'h2;
    localparam logic [1:0]      CMD_RESPONSE = 2'h3;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int              CLK_HZ         = 40_000_000;
    localparam int              TIMEOUT_US     = 25;
    localparam int              TIMEOUT_CYCLES = TIMEOUT_US * (CLK_HZ / 1_000_000);
    localparam int              TMO_CNT_W      = 12;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE     = 7'h01,
        ST_ADDR     = 7'h02,
        ST_ADDR_ACK = 7'h04,
        ST_RX       = 7'h08,
        ST_RX_ACK   = 7'h10,
        ST_TX       = 7'h20,
        ST_TX_ACK   = 7'h40
    } link_state_type;

    typedef struct packed {
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
    } bus_event_type;
endpackage : slave_flag_pkg

// ### verif/bus_master_model.sv
// Behavioural two-wire bus master that honours clock stretching
`timescale 1ns/1ps
module bus_master_model (
    output logic      scl_drv,
    output logic      sda_drv,
    input  wire logic scl_bus,
    input  wire logic sda_bus
);
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic start();
        sda_drv = 1'b0;
        #100;
        scl_drv = 1'b0;
    endtask : start
    task automatic stop();
        sda_drv = 1'b0;
        #100;
        scl_drv = 1'b1;
        #100;
        sda_drv = 1'b1;
    endtask : stop
    // SCL rises only when the slave lets go, so the clock stalls while stretched
    task automatic clk_bit(input logic b, output logic s);
        sda_drv = b;
        #100;
        scl_drv = 1'b1;
        wait (scl_bus === 1'b1);
        #50;
        s = sda_bus;
        #50;
        scl_drv = 1'b0;
    endtask : clk_bit
    task automatic xfer(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, ack);
    endtask : xfer
endmodule : bus_master_model

// ### verif/i2c_slave_flag_handling_tb_top.sv
// Self-checking bench for the two-wire slave flag block
`timescale 1ns/1ps
module i2c_slave_flag_handling_tb_top;
    import slave_flag_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, chain, err, ack;
    logic              scl_oe_n, sda_oe_n, scl_m, sda_m, scl, sda, scl_o, sda_o;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    int                miscompares, tests_run;
    // Open-drain wires with pull-ups
    assign scl = scl_oe_n & scl_m;
    assign sda = sda_oe_n & sda_m;
    i2c_slave_flag_handling #(.TIMEOUT_CYCLES(40)) i_i2c_slave_flag_handling (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .scl_in(scl), .scl_out(scl_o), .scl_oe_n,
        .sda_in(sda), .sda_out(sda_o), .sda_oe_n);
    bus_master_model i_bus_master_model (.scl_drv(scl_m), .sda_drv(sda_m), .scl_bus(scl), .sda_bus(sda));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Chained calls keep psel high so the next setup follows the completing edge
    task apb(input logic w, input logic more, input logic [7:0] a, input logic [31:0] d);
        if (!chain) @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        penable <= 1'b0;
        chain = more;
        if (!more) psel <= 1'b0;
    endtask : apb
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task complete_run();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task t_regs();
        apb(0, 0, OFF_CTRL, 0);
        chk(rd, {17'h0, CTRL_RST});
        apb(0, 0, OFF_STATUS, 0);
        chk(rd[6:0], 7'h40);
        apb(0, 0, 8'h14, 0);
        chk({rd, err}, {32'h0, 1'b1});
        chk({scl_o, sda_o}, 2'h0);
        $display("test regs done");
    endtask : t_regs
    task t_addr();
        apb(1, 0, OFF_CTRL, 32'h2A01);
        apb(1, 0, OFF_MASK, 32'h3);
        apb(1, 0, OFF_CMD, 32'h0);
        fork
            begin
                i_bus_master_model.start();
                i_bus_master_model.xfer(8'h54, ack);
            end
            begin
                repeat (4000) if (scl_oe_n !== 1'b0) @(posedge pclk);
                apb(0, 0, OFF_STATUS, 0);
                chk({irq, rd[ST_HOLD], rd[ST_ADRF]}, 3'h7);
                repeat (40) @(posedge pclk);
                chk(scl, 0);
                apb(1, 0, OFF_STATUS, 32'h5); // SCL seen low first
                repeat (3) @(posedge pclk);
                chk({scl_oe_n, irq}, 2'h2);
            end
        join
        chk(ack, 0);
        $display("test addr done");
    endtask : t_addr
    task t_data();
        fork
            i_bus_master_model.xfer(8'hA5, ack);
            begin
                repeat (4000) if (irq !== 1'b1) @(posedge pclk);
                apb(0, 0, OFF_DATA, 0);
                chk(rd[7:0], 8'hA5);
                apb(1, 1, OFF_CMD, {30'h0, CMD_RESPONSE});
                apb(0, 0, OFF_STATUS, 0);
                chk(rd[ST_DATF], 1);
                apb(0, 0, OFF_STATUS, 0);
                chk(rd[ST_DATF], 0);
            end
        join
        chk(ack, 0);
        i_bus_master_model.stop();
        repeat (4000) if (irq !== 1'b1) @(posedge pclk);
        chk(irq, 1);
        apb(1, 0, OFF_STATUS, 32'h1); // Bus idle after stop
        apb(0, 0, OFF_STATUS, 0);
        chk(rd[3:0], 0);
        $display("test data done");
    endtask : t_data
    initial begin
        {presetn, psel, penable, pwrite, chain, paddr, pwdata} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        t_regs();
        t_addr();
        t_data();
        complete_run();
    end
    initial begin
        #200000;
        miscompares++;
        complete_run();
    end
endmodule : i2c_slave_flag_handling_tb_top
